// >>> lvtr_timing_regs.sv
// lvtr_timing_regs: video timing registers of the lvds output and the
// test pattern timing generator that consumes them.
// assumes: byte register port on sys_clk; pass-through sync arrives
// from the input link decoder on the same clock.
`timescale 1ns/1ps
module lvtr_timing_regs (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    input wire logic linkHsync,
    input wire logic linkVsync,
    input wire logic linkDe,
    input wire logic [23:0] linkPixel,
    output logic chanAHsync,
    output logic chanAVsync,
    output logic chanADe,
    output logic [23:0] chanAPixel,
    output logic chanBHsync,
    output logic chanBVsync,
    output logic chanBDe,
    output logic [23:0] chanBPixel
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] chanCfg;
        logic [7:0] hswLow;
        logic [1:0] hswHigh;
        logic [7:0] vswLow;
        logic [1:0] vswHigh;
        logic [7:0] hbp;
        logic [7:0] vbp;
        logic [7:0] hfp;
        logic [7:0] vfp;
        logic tpgEn;
        logic [7:0] actPix;
        logic [7:0] actLines;
        logic [7:0] rdData;
        logic [7:0] hbpCnt;
        logic hsPrev;
        logic [23:0] pattern;
        logic hs;
        logic vs;
        logic de;
        logic [23:0] pix;
        logic bOn;
    } lvtr_state_type;

    lvtr_state_type state_ff;
    lvtr_state_type nxt_state;

    logic [lvtr_pkg::SYNC_W-1:0] hsyncWidth;
    logic [lvtr_pkg::SYNC_W-1:0] vsyncWidth;
    logic singleMode;
    lvtr_pkg::lvtr_phase_type hPhase;
    lvtr_pkg::lvtr_phase_type vPhase;
    logic hWrap;
    logic vWrap;
    logic tpgDe;
    logic [7:0] hbpLeft;

    // ==========================================================
    // assembled timing values
    assign hsyncWidth = {state_ff.hswHigh, state_ff.hswLow};
    assign vsyncWidth = {state_ff.vswHigh, state_ff.vswLow};
    assign singleMode = state_ff.chanCfg[lvtr_pkg::MODE_BIT];

    // ==========================================================
    // pattern generator axes; held at sync start while disabled
    lvtr_phase_counter #(
        .CW(lvtr_pkg::CNT_W)
    ) u_horiz (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .run(state_ff.tpgEn),
        .step(1'b1),
        .syncLen(lvtr_pkg::CNT_W'(hsyncWidth)),
        .backLen(lvtr_pkg::CNT_W'(state_ff.hbp)),
        .actLen(lvtr_pkg::CNT_W'(state_ff.actPix)),
        .frontLen(lvtr_pkg::CNT_W'(state_ff.hfp)),
        .phase(hPhase),
        .wrap(hWrap)
    );

    lvtr_phase_counter #(
        .CW(lvtr_pkg::CNT_W)
    ) u_vert (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .run(state_ff.tpgEn),
        .step(hWrap),
        .syncLen(lvtr_pkg::CNT_W'(vsyncWidth)),
        .backLen(lvtr_pkg::CNT_W'(state_ff.vbp)),
        .actLen(lvtr_pkg::CNT_W'(state_ff.actLines)),
        .frontLen(lvtr_pkg::CNT_W'(state_ff.vfp)),
        .phase(vPhase),
        .wrap(vWrap)
    );

    assign tpgDe = (hPhase == lvtr_pkg::PH_ACT) && (vPhase == lvtr_pkg::PH_ACT);

    // ==========================================================
    // next state: register writes, reads, output selection
    always_comb begin
        nxt_state = state_ff;
        // writes; reserved high bits of the narrow registers are dropped
        if (regWrStb) begin
            unique case (regAddr)
                lvtr_pkg::ADDR_CHAN_CFG: nxt_state.chanCfg = regWrData;
                lvtr_pkg::ADDR_HSW_LOW: nxt_state.hswLow = regWrData;
                lvtr_pkg::ADDR_HSW_HIGH: nxt_state.hswHigh = regWrData[1:0];
                lvtr_pkg::ADDR_VSW_LOW: nxt_state.vswLow = regWrData;
                lvtr_pkg::ADDR_VSW_HIGH: nxt_state.vswHigh = regWrData[1:0];
                lvtr_pkg::ADDR_HBP: nxt_state.hbp = regWrData;
                lvtr_pkg::ADDR_VBP: nxt_state.vbp = regWrData;
                lvtr_pkg::ADDR_HFP: nxt_state.hfp = regWrData;
                lvtr_pkg::ADDR_VFP: nxt_state.vfp = regWrData;
                lvtr_pkg::ADDR_TPG: nxt_state.tpgEn = regWrData[lvtr_pkg::TPG_BIT];
                lvtr_pkg::ADDR_ACTIVE: nxt_state.actPix = regWrData;
                lvtr_pkg::ADDR_STATUS: nxt_state.actLines = regWrData;
                default: ;
            endcase
        end
        // reads: data valid the cycle after the strobe only
        nxt_state.rdData = lvtr_pkg::RST_BYTE;
        if (regRdStb) begin
            unique case (regAddr)
                lvtr_pkg::ADDR_CHAN_CFG: nxt_state.rdData = state_ff.chanCfg;
                lvtr_pkg::ADDR_HSW_LOW: nxt_state.rdData = state_ff.hswLow;
                lvtr_pkg::ADDR_HSW_HIGH: nxt_state.rdData = {6'h00, state_ff.hswHigh};
                lvtr_pkg::ADDR_VSW_LOW: nxt_state.rdData = state_ff.vswLow;
                lvtr_pkg::ADDR_VSW_HIGH: nxt_state.rdData = {6'h00, state_ff.vswHigh};
                lvtr_pkg::ADDR_HBP: nxt_state.rdData = state_ff.hbp;
                lvtr_pkg::ADDR_VBP: nxt_state.rdData = state_ff.vbp;
                lvtr_pkg::ADDR_HFP: nxt_state.rdData = state_ff.hfp;
                lvtr_pkg::ADDR_VFP: nxt_state.rdData = state_ff.vfp;
                lvtr_pkg::ADDR_TPG: nxt_state.rdData = {3'h0, state_ff.tpgEn, 4'h0};
                lvtr_pkg::ADDR_ACTIVE: nxt_state.rdData = state_ff.actPix;
                lvtr_pkg::ADDR_STATUS: nxt_state.rdData = state_ff.actLines;
                default: nxt_state.rdData = lvtr_pkg::RST_BYTE;
            endcase
        end
        // pass-through: hsync as received, de held back by hbp pixels after
        // hsync falls, so only the horizontal back porch shapes live video;
        // porches marked pattern-only never reach this path
        // the cycle in which hsync falls is already porch, so the panel
        // sees exactly hbp blank pixels before the first active one
        nxt_state.hsPrev = linkHsync;
        hbpLeft = state_ff.hbpCnt;
        if (state_ff.hsPrev && !linkHsync) begin
            hbpLeft = state_ff.hbp;
        end
        nxt_state.hbpCnt = (hbpLeft != 8'h00) ? hbpLeft - 8'h01 : 8'h00;
        if (state_ff.tpgEn) begin
            // test pattern: sync active during sync phases, ramp colour
            nxt_state.hs = (hPhase == lvtr_pkg::PH_SYNC);
            nxt_state.vs = (vPhase == lvtr_pkg::PH_SYNC);
            nxt_state.de = tpgDe;
            nxt_state.pix = tpgDe ? state_ff.pattern : 24'h000000;
            nxt_state.pattern = vWrap ? 24'h000000 :
                (tpgDe ? state_ff.pattern + 24'h010101 : state_ff.pattern);
        end else begin
            nxt_state.hs = linkHsync;
            nxt_state.vs = linkVsync;
            nxt_state.de = linkDe && (hbpLeft == 8'h00);
            nxt_state.pix = linkPixel;
            nxt_state.pattern = 24'h000000;
        end
        nxt_state.bOn = !singleMode;
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_ff <= '0;
            state_ff.chanCfg <= lvtr_pkg::RST_CHAN_CFG;
            state_ff.actPix <= lvtr_pkg::RST_ACTIVE;
            state_ff.actLines <= lvtr_pkg::RST_ACTIVE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // outputs straight from flops; channel B muted in single mode
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            chanBHsync <= 1'b0;
            chanBVsync <= 1'b0;
            chanBDe <= 1'b0;
            chanBPixel <= 24'h000000;
        end else begin
            chanBHsync <= nxt_state.hs && nxt_state.bOn;
            chanBVsync <= nxt_state.vs && nxt_state.bOn;
            chanBDe <= nxt_state.de && nxt_state.bOn;
            chanBPixel <= nxt_state.bOn ? nxt_state.pix : 24'h000000;
        end
    end

    assign regRdData = state_ff.rdData;
    assign chanAHsync = state_ff.hs;
    assign chanAVsync = state_ff.vs;
    assign chanADe = state_ff.de;
    assign chanAPixel = state_ff.pix;

    // ==========================================================
    // checks
    a_hsw_high_mask: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (regWrStb && regAddr == lvtr_pkg::ADDR_HSW_HIGH) |=>
            hsyncWidth[9:8] == $past(regWrData[1:0]))
        else $error("hsync width high bits not taken");
    a_vsw_join: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (regWrStb && regAddr == lvtr_pkg::ADDR_VSW_LOW) |=>
            vsyncWidth[7:0] == $past(regWrData))
        else $error("vsync width low byte not taken");
    a_hsw_low_rw: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (regWrStb && regAddr == lvtr_pkg::ADDR_HSW_LOW) ##1
            (regRdStb && regAddr == lvtr_pkg::ADDR_HSW_LOW && !regWrStb) |=>
            regRdData == $past(regWrData, 2))
        else $error("hsync low byte readback wrong");
    a_read_once: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !regRdStb |=> regRdData == 8'h00)
        else $error("read data outside read slot");
    a_hbp_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!state_ff.tpgEn && state_ff.hbpCnt != 8'h00 && state_ff.hbp != 8'h00) |=>
            !state_ff.de)
        else $error("active pixel inside back porch");
    a_tpg_hsync: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state_ff.tpgEn |=> chanAHsync == $past(hPhase == lvtr_pkg::PH_SYNC))
        else $error("pattern hsync not from timing");
    a_pass_vsync: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !state_ff.tpgEn |=> chanAVsync == $past(linkVsync))
        else $error("pass-through vsync altered");
    a_single_mute: assert property (@(posedge sys_clk) disable iff (!rst_b)
        singleMode ##1 singleMode |-> !chanBDe && !chanBHsync)
        else $error("channel B active in single mode");
    a_dual_copy: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !singleMode ##1 !singleMode |-> chanBDe == chanADe)
        else $error("channel B differs in dual mode");
    a_vfp_phase: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_ff.tpgEn && vPhase == lvtr_pkg::PH_FRONT) |=> !chanADe)
        else $error("active data in vertical front porch");
endmodule

// >>> lvtr_pkg.sv
// lvtr_pkg: register map, field layout, reset values and timing states
// for the lvds video timing register block.
// assumes: byte-wide register port, one sys_clk domain.
package lvtr_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_CHAN_CFG = 8'h18;
    localparam logic [7:0] ADDR_HSW_LOW = 8'h2C;
    localparam logic [7:0] ADDR_HSW_HIGH = 8'h2D;
    localparam logic [7:0] ADDR_VSW_LOW = 8'h30;
    localparam logic [7:0] ADDR_VSW_HIGH = 8'h31;
    localparam logic [7:0] ADDR_HBP = 8'h34;
    localparam logic [7:0] ADDR_VBP = 8'h36;
    localparam logic [7:0] ADDR_HFP = 8'h38;
    localparam logic [7:0] ADDR_VFP = 8'h3A;
    localparam logic [7:0] ADDR_TPG = 8'h3C;
    localparam logic [7:0] ADDR_ACTIVE = 8'h40;
    localparam logic [7:0] ADDR_STATUS = 8'h41;
    // ==========================================================
    // field positions and widths
    localparam int MODE_BIT = 4;
    localparam int TPG_BIT = 4;
    localparam int HIGH_W = 2;
    localparam int SYNC_W = 10;
    localparam int PORCH_W = 8;
    localparam int ACT_W = 8;
    localparam int CNT_W = 12;
    // ==========================================================
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_ACTIVE = 8'h10;
    localparam logic [7:0] RST_CHAN_CFG = 8'h00;
    // ==========================================================
    // timing phases of the pattern generator, one-hot
    typedef enum logic [3:0] {
        PH_SYNC = 4'h1,
        PH_BACK = 4'h2,
        PH_ACT = 4'h4,
        PH_FRONT = 4'h8
    } lvtr_phase_type;
endpackage

// >>> lvtr_phase_counter.sv
// lvtr_phase_counter: one timing axis (horizontal or vertical) stepping
// through sync, back porch, active and front porch.
// assumes: step is a single-cycle advance from the same clock.
`timescale 1ns/1ps
module lvtr_phase_counter #(
    parameter int CW = 12
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic step,
    input wire logic [CW-1:0] syncLen,
    input wire logic [CW-1:0] backLen,
    input wire logic [CW-1:0] actLen,
    input wire logic [CW-1:0] frontLen,
    output lvtr_pkg::lvtr_phase_type phase,
    output logic wrap
);
    typedef struct packed {
        lvtr_pkg::lvtr_phase_type ph;
        logic [CW-1:0] cnt;
    } lvtr_axis_type;

    lvtr_axis_type state_ff;
    lvtr_axis_type nxt_state;
    logic [CW-1:0] curLen;
    logic last;

    // a zero length still lasts one unit so the axis can never stall
    always_comb begin
        unique case (state_ff.ph)
            lvtr_pkg::PH_SYNC: curLen = syncLen;
            lvtr_pkg::PH_BACK: curLen = backLen;
            lvtr_pkg::PH_ACT: curLen = actLen;
            lvtr_pkg::PH_FRONT: curLen = frontLen;
            default: curLen = syncLen;
        endcase
        last = (state_ff.cnt + CW'(1) >= curLen);
        wrap = step && last && (state_ff.ph == lvtr_pkg::PH_FRONT);
        nxt_state = state_ff;
        if (!run) begin
            nxt_state.ph = lvtr_pkg::PH_SYNC;
            nxt_state.cnt = '0;
        end else if (step) begin
            if (last) begin
                nxt_state.cnt = '0;
                unique case (state_ff.ph)
                    lvtr_pkg::PH_SYNC: nxt_state.ph = lvtr_pkg::PH_BACK;
                    lvtr_pkg::PH_BACK: nxt_state.ph = lvtr_pkg::PH_ACT;
                    lvtr_pkg::PH_ACT: nxt_state.ph = lvtr_pkg::PH_FRONT;
                    lvtr_pkg::PH_FRONT: nxt_state.ph = lvtr_pkg::PH_SYNC;
                    default: nxt_state.ph = lvtr_pkg::PH_SYNC;
                endcase
            end else begin
                nxt_state.cnt = state_ff.cnt + CW'(1);
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_ff.ph <= lvtr_pkg::PH_SYNC;
            state_ff.cnt <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign phase = state_ff.ph;

    a_axis_onehot: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $onehot(state_ff.ph))
        else $error("axis phase not one-hot");
endmodule

// >>> lvtr_panel_model.sv
// lvtr_panel_model: panel on one lvds channel; measures sync widths, porch gap,
// active run, line and frame periods and the pixel ramp of what it receives.
// assumes: video arrives on sys_clk, all sync and enable levels active high.
`timescale 1ns/1ps
module lvtr_panel_model (
    input wire logic sys_clk,
    input wire logic hsync,
    input wire logic vsync,
    input wire logic de,
    input wire logic [23:0] pixel,
    output logic [15:0] hsyncWidth,
    output logic [15:0] deGap,
    output logic [15:0] deLen,
    output logic [15:0] linePeriod,
    output logic [15:0] vsyncCycles,
    output logic [15:0] framePeriod,
    output logic rampBad
);
    logic [15:0] hCnt, gCnt, dCnt, lCnt, vCnt, fCnt;
    logic hPrev, dPrev, vPrev, gapOpen;
    logic [23:0] pixPrev;
    // ==========================================================
    // measurement
    // a panel only listens, so each figure is latched when its run ends
    initial begin
        {hCnt, gCnt, dCnt, lCnt, vCnt, fCnt, hsyncWidth, deGap, deLen} = '0;
        {linePeriod, vsyncCycles, framePeriod, rampBad} = '0;
        {hPrev, dPrev, vPrev, gapOpen, pixPrev} = '0;
    end
    always @(posedge sys_clk) begin
        if (hsync && !hPrev) begin
            linePeriod = lCnt;
            lCnt = 16'h0000;
        end
        lCnt = lCnt + 16'h0001;
        if (hsync) begin
            hCnt = hCnt + 16'h0001;
        end else begin
            if (hPrev) begin
                hsyncWidth = hCnt;
                gapOpen = 1'b1;
                gCnt = 16'h0000;
            end
            hCnt = 16'h0000;
        end
        // porch gap: blank cycles between sync end and first active pixel
        if (gapOpen && de) begin
            deGap = gCnt;
            gapOpen = 1'b0;
        end else if (gapOpen) begin
            gCnt = gCnt + 16'h0001;
        end
        if (de) begin
            if (dPrev && pixel !== pixPrev + 24'h010101) rampBad = 1'b1;
            dCnt = dCnt + 16'h0001;
        end else begin
            if (dPrev) deLen = dCnt;
            dCnt = 16'h0000;
        end
        // ramp judgement restarts each frame since the ramp itself restarts
        if (vsync && !vPrev) begin
            framePeriod = fCnt;
            fCnt = 16'h0000;
            rampBad = 1'b0;
        end
        fCnt = fCnt + 16'h0001;
        if (vsync) vCnt = vCnt + 16'h0001;
        else begin
            if (vPrev) vsyncCycles = vCnt;
            vCnt = 16'h0000;
        end
        {hPrev, dPrev, vPrev, pixPrev} = {hsync, de, vsync, pixel};
    end
endmodule

// >>> tb_top.sv
// tb_top: self-checking bench for the video timing registers with a register
// model, a cycle monitor and a panel model on channel A.
// assumes: one 250 MHz clock and a synchronous active-low reset.
`timescale 1ns/1ps
module tb_top;
    logic sys_clk, rst_b, regWrStb, regRdStb, linkHsync, linkVsync, linkDe;
    logic [7:0] regAddr, regWrData, regRdData, rdVal;
    logic [23:0] linkPixel, pixPrev, chanAPixel, chanBPixel;
    logic chanAHsync, chanAVsync, chanADe, chanBHsync, chanBVsync, chanBDe;
    logic [15:0] hsyncWidth, deGap, deLen, linePeriod, vsyncCycles, framePeriod;
    logic rampBad, passOn, monOn, single, hsPrev, vsPrev;
    logic [26:0] aWord, bWord;
    logic [31:0] r;
    logic [7:0] regModel [256];
    logic [7:0] addrs [12] = '{8'h18, 8'h2C, 8'h2D, 8'h30, 8'h31, 8'h34, 8'h36, 8'h38,
                               8'h3A, 8'h3C, 8'h40, 8'h41};
    // pattern geometry: hsync 3, hbp 2, active 4, hfp 2; vsync 2, vbp 1, lines 2, vfp 1
    logic [15:0] tpSet [12] = '{16'h2C03, 16'h2D00, 16'h3402, 16'h4004, 16'h3802, 16'h3002,
                                16'h3100, 16'h3601, 16'h4102, 16'h3A01, 16'h1810, 16'h3C10};
    int errors = 0;
    int comparisons = 0;
    int seed;
    assign aWord = {chanAHsync, chanAVsync, chanADe, chanAPixel};
    assign bWord = {chanBHsync, chanBVsync, chanBDe, chanBPixel};
    lvtr_timing_regs DUT (.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .linkHsync(linkHsync), .linkVsync(linkVsync),
        .linkDe(linkDe), .linkPixel(linkPixel), .chanAHsync(chanAHsync),
        .chanAVsync(chanAVsync), .chanADe(chanADe), .chanAPixel(chanAPixel),
        .chanBHsync(chanBHsync), .chanBVsync(chanBVsync), .chanBDe(chanBDe),
        .chanBPixel(chanBPixel));
    lvtr_panel_model PANEL (.sys_clk(sys_clk), .hsync(chanAHsync), .vsync(chanAVsync),
        .de(chanADe), .pixel(chanAPixel), .hsyncWidth(hsyncWidth), .deGap(deGap),
        .deLen(deLen), .linePeriod(linePeriod), .vsyncCycles(vsyncCycles),
        .framePeriod(framePeriod), .rampBad(rampBad));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // ==========================================================
    // helpers
    // reserved bits and unmapped places read back as zero; the channel
    // config byte is stored whole, only its bit 4 has a meaning here
    function automatic logic [7:0] maskOf(input logic [7:0] a);
        case (a)
            8'h3C: maskOf = 8'h10;
            8'h2D, 8'h31: maskOf = 8'h03;
            8'h18, 8'h2C, 8'h30, 8'h34, 8'h36, 8'h38, 8'h3A, 8'h40, 8'h41: maskOf = 8'hFF;
            default: maskOf = 8'h00;
        endcase
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // a write strobe stays up until the next read lowers it, so writes chain
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {regAddr, regWrData, regWrStb, regRdStb} <= {a, d, 2'b10};
        regModel[a] = d & maskOf(a);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        {regAddr, regWrStb, regRdStb} <= {a, 2'b01};
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        #1 v = regRdData;
    endtask
    task automatic ptLines(input int n);
        for (int k = 0; k < n * 28; k++) begin
            @(posedge sys_clk);
            r = $random(seed);
            linkHsync <= (k % 28) < 4;
            linkDe <= (k % 28) >= 4 && (k % 28) < 24;
            linkVsync <= k < 2;
            linkPixel <= r[23:0];
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==========================================================
    // cycle monitor: one-cycle pass-through lag and channel B mirroring
    always @(posedge sys_clk) begin
        if (passOn) check({chanAHsync, chanAVsync}, {hsPrev, vsPrev});
        if (passOn && chanADe === 1'b1) check(chanAPixel, pixPrev);
        if (monOn) check(bWord, single ? 27'h0000000 : aWord);
        {hsPrev, vsPrev, pixPrev} <= {linkHsync, linkVsync, linkPixel};
    end
    initial begin
        #200000;
        errors++;
        $display("ERROR at %0t ns: watchdog expired", $time);
        conclude();
    end
    // ==========================================================
    // main sequence
    initial begin
        seed = 32'h3E573634;
        {rst_b, regWrStb, regRdStb, linkHsync, linkVsync, linkDe} = '0;
        {passOn, monOn, single, hsPrev, vsPrev, pixPrev} = '0;
        {regAddr, regWrData, linkPixel} = '0;
        for (int i = 0; i < 256; i++) regModel[i] = lvtr_pkg::RST_BYTE;
        regModel[8'h40] = lvtr_pkg::RST_ACTIVE;
        regModel[8'h41] = lvtr_pkg::RST_ACTIVE;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        foreach (addrs[i]) begin
            rd(addrs[i], rdVal);
            check(rdVal, regModel[addrs[i]]);
        end
        $display("test reset values done");
        foreach (addrs[i]) begin
            r = $random(seed);
            wr(addrs[i], r[7:0]);
            rd(addrs[i], rdVal);
            check(rdVal, regModel[addrs[i]]);
        end
        wr(8'h2C, 8'h5A);
        rd(8'h2C, rdVal);
        check(rdVal, 8'h5A);
        @(posedge sys_clk);
        #1 check(regRdData, 8'h00);
        wr(8'h2E, 8'hA5);
        rd(8'h2E, rdVal);
        check(rdVal, regModel[8'h2E]);
        $display("test register access done");
        // pass-through in both channel modes; pattern-only porches randomised
        for (int m = 0; m < 2; m++) begin
            {monOn, passOn} = 2'b00;
            single = (m == 0);
            r = $random(seed);
            wr(8'h3C, 8'h00);
            wr(8'h18, single ? 8'h10 : 8'h00);
            wr(8'h34, single ? 8'h05 : 8'h09);
            wr(8'h36, r[7:0]);
            wr(8'h38, r[15:8]);
            wr(8'h3A, r[23:16]);
            rd(8'h34, rdVal);
            check(rdVal, single ? 8'h05 : 8'h09);
            repeat (2) @(posedge sys_clk);
            #1 {monOn, passOn} = 2'b11;
            ptLines(3);
            check(deGap, single ? 16'h0005 : 16'h0009);
        end
        $display("test pass-through done");
        {monOn, passOn} = 2'b00;
        single = 1'b1;
        foreach (tpSet[i]) wr(tpSet[i][15:8], tpSet[i][7:0]);
        rd(8'h3C, rdVal);
        repeat (3) @(posedge sys_clk);
        #1 monOn = 1'b1;
        repeat (300) @(posedge sys_clk);
        check(hsyncWidth, 16'h0003);
        check(deGap, 16'h0002);
        check(deLen, 16'h0004);
        check(linePeriod, 16'h000B);
        check(vsyncCycles, 16'h0016);
        check(framePeriod, 16'h0042);
        check(rampBad, 1'b0);
        wr(8'h2D, 8'h01);
        wr(8'h2C, 8'h02);
        rd(8'h2D, rdVal);
        repeat (600) @(posedge sys_clk);
        check(hsyncWidth, 16'h0102);
        $display("test pattern timing done");
        monOn = 1'b0;
        conclude();
    end
endmodule
